//--- hw/dmc_chan_cfg.sv
// dmc_chan_cfg: per-channel destination, count and addressing setup
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// (R1) each channel keeps destination address bits 15..0 in its own register.
// (R2) each channel has a 16-bit count register loaded by software.
// (R3) while active the count register shows the remaining units, per unit.
// (R4) count is value plus one: 0 means one unit, all ones means 65,536.
// (R5) after terminal count the count reads back the loaded value, not zero.
// (R6) software leaves the addressing control word alone while active.
// (R7) the addressing control word is a whole 16-bit access, reset to zero.
// (R8) bit 14 picks 8/16-bit units; step fields 00 inc, 01 dec, 10 fixed.
// (R9) destination is 26 bits; upper word has bits 25..16 and a RAM select.
// (R10) four independent channels, each with its own set of registers.
// (R11) terminal count sets the end flag; reading it clears the flag.
// (R12) changing setup mid-transfer is preceded by a reinitialise write.
module dmc_chan_cfg
   import dmc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [DMC_NCH-1:0] unit_done,
   output logic [DMC_NCH-1:0] chan_active,
   output logic [DMC_NCH*DMC_DADDR_W-1:0] dest_addr,
   output logic [DMC_NCH-1:0] ram_space_sel,
   output logic [DMC_NCH-1:0] unit_size_sel,
   output logic [DMC_NCH*2-1:0] src_step,
   output logic [DMC_NCH*2-1:0] dst_step,
   output logic [DMC_NCH-1:0] transfer_end_flag,
   output logic irq
);

   // address decode shared by the read and write paths
   function automatic dmc_hit_s decode(input logic [31:0] a);
      dmc_hit_s h;
      h.kind = DMC_K_NONE;
      h.ch = '0;
      for (int i = 0; i < DMC_NCH; i++) begin
         if (a[31:2] == DMC_DLO_IDX[i][29:0]) begin
            h.kind = DMC_K_DLO;
            h.ch = DMC_CH_W'(i);
         end
         if (a[31:2] == DMC_DHI_IDX[i][29:0]) begin
            h.kind = DMC_K_DHI;
            h.ch = DMC_CH_W'(i);
         end
         if (a[31:2] == DMC_CNT_IDX[i][29:0]) begin
            h.kind = DMC_K_CNT;
            h.ch = DMC_CH_W'(i);
         end
         if (a[31:2] == DMC_ADC_IDX[i][29:0]) begin
            h.kind = DMC_K_ADC;
            h.ch = DMC_CH_W'(i);
         end
         if (a[31:2] == DMC_CTL_IDX[i][29:0]) begin
            h.kind = DMC_K_CTL;
            h.ch = DMC_CH_W'(i);
         end
      end
      if (a[31:2] == DMC_IST_IDX[29:0]) begin
         h.kind = DMC_K_IST;
      end
      if (a[31:2] == DMC_IMSK_IDX[29:0]) begin
         h.kind = DMC_K_IMSK;
      end
      return h;
   endfunction

   // byte-lane merge for the 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old,
         input logic [15:0] d, input logic [1:0] s);
      return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   logic aw_full;
   logic w_full;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic wr_ok;
   logic wr_en;
   dmc_hit_s wr_hit;
   dmc_hit_s rd_hit;
   logic rd_hs;
   logic rd_ok;
   logic [31:0] rd_word;
   logic [15:0] dlo_a [DMC_NCH];
   logic [15:0] dhi_a [DMC_NCH];
   logic [15:0] cnt_a [DMC_NCH];
   logic [15:0] adc_a [DMC_NCH];
   logic [DMC_NCH-1:0] term_v;
   logic [DMC_NCH-1:0] int_stat;
   logic [DMC_NCH-1:0] int_mask;

   // address and data are taken independently, one write at a time
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign do_write = aw_full && w_full && !s_axi_bvalid;
   assign wr_hit = decode(aw_addr);
   assign wr_en = do_write && wr_ok;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         w_full <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_full <= 1'b0;
      end
   end

   // write legality; a refused write changes nothing and answers SLVERR
   always_comb begin
      wr_ok = 1'b1;
      case (wr_hit.kind)
         DMC_K_NONE: wr_ok = 1'b0;
         DMC_K_ADC: begin
            // half-word writes and live-channel writes are refused [R7] [R6]
            wr_ok = (w_strb[1:0] == 2'b11) && !chan_active[wr_hit.ch];
            // the reserved step code never reaches the engine [R8]
            if (w_data[DMC_ADC_SRC_LSB +: 2] == DMC_STEP_BAD ||
                  w_data[DMC_ADC_DST_LSB +: 2] == DMC_STEP_BAD) begin
               wr_ok = 1'b0;
            end
         end
         DMC_K_CTL: wr_ok = w_strb[0];
         DMC_K_IST: wr_ok = w_strb[0];
         DMC_K_IMSK: wr_ok = w_strb[0];
         default: wr_ok = 1'b1;
      endcase
   end

   // write response, held until the master takes it
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= DMC_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? DMC_RESP_OKAY : DMC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // four identical channels, each with its own register set [R10]
   for (genvar g = 0; g < DMC_NCH; g++) begin : g_ch
      logic sel;
      logic init;
      logic [15:0] dlo;
      logic [15:0] dhi;
      logic [15:0] cnt;
      logic [15:0] cnt_ld;
      logic [15:0] adc;
      logic act;
      logic endf;
      logic rd_clr;

      assign sel = wr_en && (wr_hit.ch == DMC_CH_W'(g));
      assign init = sel && wr_hit.kind == DMC_K_CTL &&
         w_data[DMC_CTL_INIT_BIT];
      // last unit: the counter already stood at zero [R4]
      assign term_v[g] = act && unit_done[g] && (cnt == 16'h0000);
      assign rd_clr = rd_hs && rd_hit.kind == DMC_K_CTL &&
         rd_hit.ch == DMC_CH_W'(g);

      // destination address halves [R1] [R9]
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            dlo <= DMC_DLO_RST;
         end else if (sel && wr_hit.kind == DMC_K_DLO) begin
            dlo <= merge16(dlo, w_data[15:0], w_strb[1:0]); // [R1]
         end
      end

      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            dhi <= DMC_DHI_RST;
         end else if (sel && wr_hit.kind == DMC_K_DHI) begin
            dhi <= merge16(dhi, w_data[15:0], w_strb[1:0]) &
               DMC_DHI_WMASK; // [R9]
         end
      end

      // counter keeps a copy of the load so it can read it back later
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            cnt <= DMC_CNT_RST;
            cnt_ld <= DMC_CNT_RST;
         end else if (sel && wr_hit.kind == DMC_K_CNT) begin
            cnt <= merge16(cnt, w_data[15:0], w_strb[1:0]); // [R2]
            cnt_ld <= merge16(cnt, w_data[15:0], w_strb[1:0]);
         end else if (init) begin
            cnt <= cnt_ld; // [R12]
         end else if (term_v[g]) begin
            cnt <= cnt_ld; // [R5]
         end else if (act && unit_done[g]) begin
            cnt <= cnt - 16'h0001; // [R3]
         end
      end

      // addressing control, whole-word only and zero after reset
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            adc <= DMC_ADC_RST; // [R7]
         end else if (sel && wr_hit.kind == DMC_K_ADC) begin
            adc <= w_data[15:0] & DMC_ADC_WMASK; // [R7] [R8]
         end
      end

      // run state: reinitialise stops the channel and rewinds the count
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            act <= 1'b0;
         end else if (init) begin
            act <= 1'b0; // [R12]
         end else if (sel && wr_hit.kind == DMC_K_CTL) begin
            act <= w_data[DMC_CTL_ACT_BIT];
         end else if (term_v[g]) begin
            act <= 1'b0;
         end
      end

      // end flag: a terminal count in the read cycle still sets it
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn) begin
            endf <= 1'b0;
         end else if (term_v[g]) begin
            endf <= 1'b1; // [R11]
         end else if (rd_clr) begin
            endf <= 1'b0; // [R11]
         end
      end

      assign dlo_a[g] = dlo;
      assign dhi_a[g] = dhi;
      assign cnt_a[g] = cnt;
      assign adc_a[g] = adc;
      assign chan_active[g] = act;
      assign transfer_end_flag[g] = endf;
      assign dest_addr[g*DMC_DADDR_W +: DMC_DADDR_W] = {dhi[9:0], dlo};
      assign ram_space_sel[g] = dhi[DMC_DHI_RAM_BIT];
      assign unit_size_sel[g] = adc[DMC_ADC_SIZE_BIT]; // [R8]
      assign src_step[g*2 +: 2] = adc[DMC_ADC_SRC_LSB +: 2];
      assign dst_step[g*2 +: 2] = adc[DMC_ADC_DST_LSB +: 2];
   end

   // interrupt status: set wins over a write-one clear
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         int_stat <= '0;
      end else if (wr_en && wr_hit.kind == DMC_K_IST) begin
         int_stat <= (int_stat & ~w_data[DMC_NCH-1:0]) | term_v;
      end else begin
         int_stat <= int_stat | term_v;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         int_mask <= DMC_IMSK_RST;
      end else if (wr_en && wr_hit.kind == DMC_K_IMSK) begin
         int_mask <= w_data[DMC_NCH-1:0];
      end
   end

   // registered so the line is glitch free; lags status by one cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_stat & int_mask);
      end
   end

   // read path: one read at a time, data held until rready
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_hs = s_axi_arvalid && s_axi_arready;
   assign rd_hit = decode(s_axi_araddr);

   always_comb begin
      rd_word = '0;
      rd_ok = 1'b1;
      case (rd_hit.kind)
         DMC_K_DLO: rd_word[15:0] = dlo_a[rd_hit.ch];
         DMC_K_DHI: rd_word[15:0] = dhi_a[rd_hit.ch];
         DMC_K_CNT: rd_word[15:0] = cnt_a[rd_hit.ch]; // [R3] [R5]
         DMC_K_ADC: begin
            // a live channel's control word is not shown [R6]
            rd_ok = !chan_active[rd_hit.ch];
            rd_word[15:0] = rd_ok ? adc_a[rd_hit.ch] : 16'h0000;
         end
         DMC_K_CTL: begin
            rd_word[DMC_CTL_END_BIT] = transfer_end_flag[rd_hit.ch];
            rd_word[DMC_CTL_ACT_BIT] = chan_active[rd_hit.ch];
         end
         DMC_K_IST: rd_word[DMC_NCH-1:0] = int_stat;
         DMC_K_IMSK: rd_word[DMC_NCH-1:0] = int_mask;
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= DMC_RESP_OKAY;
      end else if (rd_hs) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? DMC_RESP_OKAY : DMC_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

//--- hw/dmc_pkg.sv
// dmc_pkg: register map, field layout and reset values of the channel setup
`default_nettype none
package dmc_pkg;

   localparam int DMC_NCH = 4;
   localparam int DMC_CH_W = 2;
   localparam int DMC_DADDR_W = 26;

   // register indices; byte address is four times the index
   localparam logic [31:0] DMC_DLO_IDX [DMC_NCH] =
      '{32'h0FFFF084, 32'h0FFFF08C, 32'h0FFFF094, 32'h0FFFF09C};
   localparam logic [31:0] DMC_DHI_IDX [DMC_NCH] =
      '{32'h0FFFF086, 32'h0FFFF08E, 32'h0FFFF096, 32'h0FFFF09E};
   localparam logic [31:0] DMC_CNT_IDX [DMC_NCH] =
      '{32'hFFFFF0C0, 32'hFFFFF0C2, 32'hFFFFF0C4, 32'hFFFFF0C6};
   localparam logic [31:0] DMC_ADC_IDX [DMC_NCH] =
      '{32'h0FFFF0D0, 32'h0FFFF0D2, 32'hFFFFF0D4, 32'hFFFFF0D6};
   localparam logic [31:0] DMC_CTL_IDX [DMC_NCH] =
      '{32'h0FFFF0E0, 32'h0FFFF0E2, 32'h0FFFF0E4, 32'h0FFFF0E6};
   localparam logic [31:0] DMC_IST_IDX = 32'h0FFFF0F0;
   localparam logic [31:0] DMC_IMSK_IDX = 32'h0FFFF0F2;

   // upper destination word: space select and address bits 25..16
   localparam int DMC_DHI_RAM_BIT = 15;
   localparam logic [15:0] DMC_DHI_WMASK = 16'h83FF;
   // addressing control word fields
   localparam int DMC_ADC_SIZE_BIT = 14;
   localparam int DMC_ADC_SRC_LSB = 6;
   localparam int DMC_ADC_DST_LSB = 4;
   localparam logic [15:0] DMC_ADC_WMASK = 16'h40F0;
   localparam logic [1:0] DMC_STEP_BAD = 2'h3;
   // channel control byte
   localparam int DMC_CTL_ACT_BIT = 0;
   localparam int DMC_CTL_INIT_BIT = 2;
   localparam int DMC_CTL_END_BIT = 7;

   // reset values
   localparam logic [15:0] DMC_DLO_RST = 16'h0000;
   localparam logic [15:0] DMC_DHI_RST = 16'h0000;
   localparam logic [15:0] DMC_CNT_RST = 16'h0000;
   localparam logic [15:0] DMC_ADC_RST = 16'h0000;
   localparam logic [DMC_NCH-1:0] DMC_IMSK_RST = 4'h0;

   localparam logic [1:0] DMC_RESP_OKAY = 2'h0;
   localparam logic [1:0] DMC_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      DMC_K_NONE, DMC_K_DLO, DMC_K_DHI, DMC_K_CNT,
      DMC_K_ADC, DMC_K_CTL, DMC_K_IST, DMC_K_IMSK
   } dmc_kind_e;

   typedef struct packed {
      dmc_kind_e kind;
      logic [DMC_CH_W-1:0] ch;
   } dmc_hit_s;

endpackage
`default_nettype wire

//--- verification/dmc_chan_cfg_monitor.sv
// dmc_chan_cfg_monitor: bus and engine-side checks on the setup block
`timescale 1ns/1ps
`default_nettype none
module dmc_chan_cfg_monitor
   import dmc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [DMC_NCH-1:0] unit_done,
   input wire logic [DMC_NCH-1:0] chan_active,
   input wire logic [DMC_NCH*2-1:0] src_step,
   input wire logic [DMC_NCH*2-1:0] dst_step,
   input wire logic [DMC_NCH-1:0] transfer_end_flag
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // responses must stand until the master takes them
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");
   property p_r_soon;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_soon: assert property (p_r_soon)
      else $error("read answer late");
   // every register fits in the low 16 bits, upper half reads zero
   property p_r_upper;
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
   endproperty
   a_r_upper: assert property (p_r_upper)
      else $error("read data upper half not zero");
   property p_busy_gate;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_busy_gate: assert property (p_busy_gate)
      else $error("write taken while response pending");
   // the prohibited step code never reaches the engine
   property p_no_bad_step;
      ((src_step & (src_step >> 1)) & 8'h55) == 8'h00 &&
      ((dst_step & (dst_step >> 1)) & 8'h55) == 8'h00;
   endproperty
   a_no_bad_step: assert property (p_no_bad_step)
      else $error("prohibited step code active");
   property p_end_stops;
      |(transfer_end_flag & ~$past(transfer_end_flag)) |->
      (transfer_end_flag & ~$past(transfer_end_flag) & chan_active) == 4'h0;
   endproperty
   a_end_stops: assert property (p_end_stops)
      else $error("channel still active at end flag");
   property p_end_cause;
      |(transfer_end_flag & ~$past(transfer_end_flag)) |->
      (transfer_end_flag & ~$past(transfer_end_flag)
       & ~$past(unit_done & chan_active)) == 4'h0;
   endproperty
   a_end_cause: assert property (p_end_cause)
      else $error("end flag without a final unit");
   // a channel only starts through a register write
   property p_start_by_write;
      |(chan_active & ~$past(chan_active)) |-> $rose(s_axi_bvalid);
   endproperty
   a_start_by_write: assert property (p_start_by_write)
      else $error("channel started without a write");
endmodule

bind dmc_chan_cfg dmc_chan_cfg_monitor u_mon (.sys_clk, .resetn,
   .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .unit_done, .chan_active, .src_step, .dst_step, .transfer_end_flag);
`default_nettype wire

//--- verification/dmc_chan_cfg_tb_top.sv
// dmc_chan_cfg_tb_top: self-checking bench for the channel setup block
`timescale 1ns/1ps
`default_nettype none
module dmc_chan_cfg_tb_top
   import dmc_pkg::*;
;
   typedef struct packed {
      logic [31:0] a;
      logic [15:0] w;
      logic [3:0] s;
      logic [1:0] wr;
      logic [15:0] r;
      logic [1:0] rr;
   } dmc_row_s;
   localparam logic [1:0] OK = DMC_RESP_OKAY;
   localparam logic [1:0] ER = DMC_RESP_SLVERR;
   // plain register traffic: write, expected answer, readback
   localparam dmc_row_s ROWS [11] = '{
      '{DMC_DLO_IDX[0] << 2, 16'hA55A, 4'hF, OK, 16'hA55A, OK},
      '{DMC_DLO_IDX[3] << 2, 16'h5AA5, 4'h3, OK, 16'h5AA5, OK},
      '{DMC_DLO_IDX[1] << 2, 16'h12CD, 4'h1, OK, 16'h00CD, OK},
      '{DMC_CNT_IDX[2] << 2, 16'hFFFF, 4'h3, OK, 16'hFFFF, OK},
      '{DMC_ADC_IDX[1] << 2, 16'h4060, 4'h3, OK, 16'h4060, OK},
      '{DMC_ADC_IDX[1] << 2, 16'h1234, 4'h1, ER, 16'h4060, OK},
      '{DMC_ADC_IDX[2] << 2, 16'h00F0, 4'h3, ER, 16'h0000, OK},
      '{DMC_ADC_IDX[3] << 2, 16'h4090, 4'h3, OK, 16'h4090, OK},
      '{DMC_DHI_IDX[2] << 2, 16'hFFFF, 4'h3, OK, 16'h83FF, OK},
      '{DMC_CTL_IDX[2] << 2, 16'h0001, 4'h2, ER, 16'h0000, OK},
      '{32'h00000100, 16'h0001, 4'hF, ER, 16'h0000, ER}};

   logic sys_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [DMC_NCH-1:0] unit_done, chan_active, ram_space_sel, unit_size_sel;
   logic [DMC_NCH-1:0] transfer_end_flag;
   logic [DMC_NCH*DMC_DADDR_W-1:0] dest_addr;
   logic [DMC_NCH*2-1:0] src_step, dst_step;
   logic [7:0] gap;
   int fail_count, cmp_count, cyc, ndone;

   dmc_chan_cfg dut (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .unit_done, .chan_active, .dest_addr, .ram_space_sel, .unit_size_sel,
      .src_step, .dst_step, .transfer_end_flag, .irq);
   dmc_engine_model u_eng (.sys_clk, .resetn, .chan_active, .gap, .unit_done);

   // clock, unit counter and hang guard
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (unit_done[0]) ndone <= ndone + 1;
      if (cyc == 5000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   // ready is judged at the falling edge, release follows the next rise
   task automatic axi_wr(input logic [31:0] a, d, input logic [3:0] s);
      logic ta, tw, da, dw;
      da = 1'b0;
      dw = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(da && dw)) begin
         @(negedge sys_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         da |= ta;
         dw |= tw;
      end
      // bready comes a cycle late so the response must stand meanwhile
      do @(negedge sys_clk); while (!s_axi_bvalid);
      @(posedge sys_clk);
      s_axi_bready <= 1'b1;
      @(negedge sys_clk);
      resp = s_axi_bresp;
      @(posedge sys_clk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [31:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(negedge sys_clk); while (!s_axi_arready);
      @(posedge sys_clk);
      s_axi_arvalid <= 1'b0;
      // rready comes a cycle late so the data must stand meanwhile
      do @(negedge sys_clk); while (!s_axi_rvalid);
      @(posedge sys_clk);
      s_axi_rready <= 1'b1;
      @(negedge sys_clk);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge sys_clk);
      s_axi_rready <= 1'b0;
   endtask

   initial begin
      {sys_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata} = '0;
      {s_axi_araddr, s_axi_wstrb, cyc, ndone, fail_count, cmp_count} = '0;
      gap = 8'h28;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      axi_rd(DMC_ADC_IDX[0] << 2);
      chk("adc0 reset", 32'h0, rd);
      chk("active reset", 32'h0, {28'h0, chan_active});
      $display("test reset done");
      foreach (ROWS[i]) begin
         axi_wr(ROWS[i].a, {16'h0, ROWS[i].w}, ROWS[i].s);
         chk("wresp", {30'h0, ROWS[i].wr}, {30'h0, resp});
         axi_rd(ROWS[i].a);
         chk("rdata", {16'h0, ROWS[i].r}, rd);
         chk("rresp", {30'h0, ROWS[i].rr}, {30'h0, resp});
      end
      chk("dest0", 32'hA55A, {16'h0, dest_addr[15:0]});
      chk("dest3", 32'h5AA5, {16'h0, dest_addr[78+:16]});
      chk("dest1", 32'h00CD, {16'h0, dest_addr[26+:16]});
      chk("dest2", 32'h03FF0000, {6'h0, dest_addr[52+:26]});
      chk("ram sel", 32'h4, {28'h0, ram_space_sel});
      chk("size", 32'hA, {28'h0, unit_size_sel});
      chk("steps", 32'h8448, {16'h0, src_step, dst_step});
      $display("test table done");
      axi_wr(DMC_CNT_IDX[0] << 2, 32'h2, 4'h3);
      axi_wr(DMC_CTL_IDX[0] << 2, 32'h1, 4'h1);
      while (!unit_done[0]) @(negedge sys_clk);
      axi_rd(DMC_CNT_IDX[0] << 2);
      chk("count mid", 32'h1, rd);
      axi_rd(DMC_ADC_IDX[0] << 2);
      chk("adc busy", {30'h0, ER}, {30'h0, resp});
      while (!transfer_end_flag[0]) @(negedge sys_clk);
      chk("units", 32'h3, ndone);
      chk("irq masked", 32'h0, {31'h0, irq});
      axi_wr(DMC_IMSK_IDX << 2, 32'h1, 4'h1);
      repeat (2) @(negedge sys_clk);
      chk("irq on", 32'h1, {31'h0, irq});
      axi_rd(DMC_IST_IDX << 2);
      chk("status", 32'h1, rd & 32'hF);
      axi_wr(DMC_IST_IDX << 2, 32'h1, 4'h1);
      repeat (2) @(negedge sys_clk);
      chk("irq clear", 32'h0, {31'h0, irq});
      axi_rd(DMC_CNT_IDX[0] << 2);
      chk("count after", 32'h2, rd);
      axi_rd(DMC_CTL_IDX[0] << 2);
      chk("end read", 32'h1, {31'h0, rd[DMC_CTL_END_BIT]});
      chk("end clr", 32'h0, {31'h0, transfer_end_flag[0]});
      $display("test transfer done");
      axi_wr(DMC_CNT_IDX[1] << 2, 32'h5, 4'h3);
      axi_wr(DMC_CTL_IDX[1] << 2, 32'h1, 4'h1);
      while (!unit_done[1]) @(negedge sys_clk);
      axi_wr(DMC_CTL_IDX[1] << 2, 32'h4, 4'h1);
      chk("reinit stop", 32'h0, {31'h0, chan_active[1]});
      axi_rd(DMC_CNT_IDX[1] << 2);
      chk("reinit count", 32'h5, rd);
      $display("test reinit done");
      tally_and_finish();
   end
endmodule
`default_nettype wire

//--- verification/dmc_engine_model.sv
// dmc_engine_model: transfer engine that consumes units of running channels
`timescale 1ns/1ps
`default_nettype none
module dmc_engine_model
   import dmc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [DMC_NCH-1:0] chan_active,
   input wire logic [7:0] gap,
   output logic [DMC_NCH-1:0] unit_done
);
   logic [7:0] wait_cnt [DMC_NCH];

   // one unit every gap+1 cycles; a large gap lets software look mid-run
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         unit_done <= '0;
         for (int g = 0; g < DMC_NCH; g++) wait_cnt[g] <= 8'h00;
      end else begin
         for (int g = 0; g < DMC_NCH; g++) begin
            unit_done[g] <= chan_active[g] && wait_cnt[g] == gap;
            if (!chan_active[g] || wait_cnt[g] == gap) wait_cnt[g] <= 8'h00;
            else wait_cnt[g] <= wait_cnt[g] + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire
